// File: inc/phy_ctl_pkg.sv
// Constants, codes and helpers shared by the phy control executor.
// Assumes request bytes arrive in order, byte 0 first, one per clock.
//
// Notes on behaviour
// - Request frame type must be 40h.
// - Function code 91h selects phy control.
// - Byte 9 selects the target phy.
// - Byte 10 is the phy operation code.
// - 01h: link or internal reset, enable.
// - 01h keeps affiliation, bypasses spin-up hold.
// - 01h answers at once, no reset wait.
// - 02h: reset, enable, hard reset to SAS.
// - 02h to SATA bypasses spin-up hold.
// - 02h clears any affiliation on phy.
// - 02h answers without waiting for reset.
// - 03h disables the selected phy.
// - Later 01h or 02h enables it again.
// - 05h clears the phy error log counters.
// - Unsupported target never dispatches 91h frames.
// - Rate codes 0h keep, 8h, 9h; reset uses them.
// - Bad rates keep stored values, skip operation.
// - Resetting or disabling own connection phy refused.
// - Timeout loaded only with update bit set.
// ============================================================
// Package
package phy_ctl_pkg;
    // Frame layout
    localparam int FRAME_LEN = 44;
    localparam logic [5:0] IDX_LAST = 6'h2B;
    localparam logic [5:0] IDX_TYPE = 6'h00;
    localparam logic [5:0] IDX_FUNC = 6'h01;
    localparam logic [5:0] IDX_PHY = 6'h09;
    localparam logic [5:0] IDX_OP = 6'h0A;
    localparam logic [5:0] IDX_MIN = 6'h20;
    localparam logic [5:0] IDX_MAX = 6'h21;
    localparam logic [5:0] IDX_UPD = 6'h22;
    localparam int UPD_BIT = 7;
    localparam logic [5:0] IDX_TMO = 6'h24;
    localparam logic [5:0] IDX_CRC = 6'h28;
    // Frame and function codes
    localparam logic [7:0] FRAME_TYPE_REQ = 8'h40;
    localparam logic [7:0] FUNC_PHY_CTL = 8'h91;
    // Phy operations
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_LINK_RESET = 8'h01;
    localparam logic [7:0] OP_HARD_RESET = 8'h02;
    localparam logic [7:0] OP_DISABLE = 8'h03;
    localparam logic [7:0] OP_CLEAR_LOG = 8'h05;
    // Link rate codes
    localparam logic [3:0] RATE_KEEP = 4'h0;
    localparam logic [3:0] RATE_1G5 = 4'h8;
    localparam logic [3:0] RATE_3G0 = 4'h9;
    // Function results
    localparam logic [7:0] RES_ACCEPTED = 8'h00;
    localparam logic [7:0] RES_UNKNOWN_FUNC = 8'h01;
    localparam logic [7:0] RES_FAILED = 8'h02;
    localparam logic [7:0] RES_PHY_VACANT = 8'h10;
    // Phy count and reset values
    localparam int NUM_PHYS = 8;
    localparam int PHY_IDX_W = 3;
    localparam logic [7:0] NUM_PHYS_B = 8'h08;
    localparam logic [3:0] MIN_RATE_RST = 4'h8;
    localparam logic [3:0] MAX_RATE_RST = 4'h9;
    localparam logic [3:0] TMO_RST = 4'h0;

    // Rate code is keep or a supported rate
    function automatic logic rate_code_ok(input logic [3:0] c);
        return (c == RATE_KEEP) || (c == RATE_1G5) || (c == RATE_3G0);
    endfunction
endpackage

// File: logic/frame_capture.sv
// Byte stream capture of one 44-byte request frame into fields.
// Assumes one byte per cycle while rx_valid, rx_last on the final byte.
// ============================================================
// Frame capture
module frame_capture (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    // Captured frame
    output logic done,
    output logic bad,
    output logic [7:0] ftype,
    output logic [7:0] func,
    output logic [7:0] phy_id,
    output logic [7:0] op,
    output logic [3:0] min_code,
    output logic [3:0] max_code,
    output logic upd,
    output logic [3:0] tmo,
    output logic [31:0] crc
);
    logic [5:0] idx_reg, idx_next;
    logic done_reg, done_next, bad_reg, bad_next;
    logic [7:0] ftype_reg, ftype_next, func_reg, func_next;
    logic [7:0] phy_reg, phy_next, op_reg, op_next;
    logic [3:0] min_reg, min_next, max_reg, max_next, tmo_reg, tmo_next;
    logic upd_reg, upd_next;
    logic [31:0] crc_reg, crc_next;

    // Index tracking and field latching
    always_comb begin
        idx_next = idx_reg;
        done_next = 1'b0;
        bad_next = 1'b0;
        ftype_next = ftype_reg;
        func_next = func_reg;
        phy_next = phy_reg;
        op_next = op_reg;
        min_next = min_reg;
        max_next = max_reg;
        upd_next = upd_reg;
        tmo_next = tmo_reg;
        crc_next = crc_reg;
        if (rx_valid) begin
            if (idx_reg == phy_ctl_pkg::IDX_TYPE) ftype_next = rx_byte;
            if (idx_reg == phy_ctl_pkg::IDX_FUNC) func_next = rx_byte;
            if (idx_reg == phy_ctl_pkg::IDX_PHY) phy_next = rx_byte;
            if (idx_reg == phy_ctl_pkg::IDX_OP) op_next = rx_byte;
            if (idx_reg == phy_ctl_pkg::IDX_MIN) min_next = rx_byte[7:4];
            if (idx_reg == phy_ctl_pkg::IDX_MAX) max_next = rx_byte[7:4];
            if (idx_reg == phy_ctl_pkg::IDX_UPD) begin
                upd_next = rx_byte[phy_ctl_pkg::UPD_BIT];
            end
            if (idx_reg == phy_ctl_pkg::IDX_TMO) tmo_next = rx_byte[3:0];
            if (idx_reg >= phy_ctl_pkg::IDX_CRC) begin
                crc_next = {crc_reg[23:0], rx_byte};
            end
            if (rx_last) begin
                idx_next = 6'h00;
                done_next = (idx_reg == phy_ctl_pkg::IDX_LAST);
                bad_next = (idx_reg != phy_ctl_pkg::IDX_LAST);
            end else if (idx_reg != 6'h3F) begin
                idx_next = idx_reg + 6'h01;
            end
        end
    end

    // Capture registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idx_reg <= 6'h00;
            done_reg <= 1'b0;
            bad_reg <= 1'b0;
            ftype_reg <= 8'h00;
            func_reg <= 8'h00;
            phy_reg <= 8'h00;
            op_reg <= 8'h00;
            min_reg <= 4'h0;
            max_reg <= 4'h0;
            upd_reg <= 1'b0;
            tmo_reg <= 4'h0;
            crc_reg <= 32'h0000_0000;
        end else begin
            idx_reg <= idx_next;
            done_reg <= done_next;
            bad_reg <= bad_next;
            ftype_reg <= ftype_next;
            func_reg <= func_next;
            phy_reg <= phy_next;
            op_reg <= op_next;
            min_reg <= min_next;
            max_reg <= max_next;
            upd_reg <= upd_next;
            tmo_reg <= tmo_next;
            crc_reg <= crc_next;
        end
    end

    assign done = done_reg;
    assign bad = bad_reg;
    assign ftype = ftype_reg;
    assign func = func_reg;
    assign phy_id = phy_reg;
    assign op = op_reg;
    assign min_code = min_reg;
    assign max_code = max_reg;
    assign upd = upd_reg;
    assign tmo = tmo_reg;
    assign crc = crc_reg;
endmodule

// File: logic/phy_ctl_exec.sv
// Phy control request executor: decodes a request, acts on one phy.
// Assumes CRC checking and response framing are done elsewhere.
// ============================================================
// Executor
module phy_ctl_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Request byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    // Configuration and phy status
    input wire logic support_en,
    input wire logic [7:0] conn_phy_id,
    input wire logic [phy_ctl_pkg::NUM_PHYS-1:0] phy_virtual,
    input wire logic [phy_ctl_pkg::NUM_PHYS-1:0] attached_sata,
    // Response
    output logic resp_valid,
    output logic [7:0] resp_function,
    output logic [7:0] resp_result,
    output logic frame_drop,
    output logic [31:0] req_crc,
    // Phy controls
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] phy_enable,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] link_reset,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] hard_reset,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] internal_reset,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] spinup_bypass,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] affil_clear,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0] errlog_clear,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0][3:0] min_rate,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0][3:0] max_rate,
    output logic [phy_ctl_pkg::NUM_PHYS-1:0][3:0] pp_timeout
);
    localparam int N = phy_ctl_pkg::NUM_PHYS;
    logic cap_done, cap_bad, cap_upd;
    logic [7:0] cap_type, cap_func, cap_phy, cap_op;
    logic [3:0] cap_min, cap_max, cap_tmo;
    logic [phy_ctl_pkg::PHY_IDX_W-1:0] sel;
    logic [3:0] eff_min, eff_max;
    logic op_known, rate_bad, self_conn;
    logic [N-1:0] onehot;
    logic resp_valid_reg, resp_valid_next, drop_reg, drop_next;
    logic [7:0] func_reg, func_next, result_reg, result_next;
    logic [N-1:0] en_reg, en_next, lr_reg, lr_next, hr_reg, hr_next;
    logic [N-1:0] ir_reg, ir_next, sb_reg, sb_next;
    logic [N-1:0] ac_reg, ac_next, ec_reg, ec_next;
    logic [N-1:0][3:0] min_reg, min_next, max_reg, max_next;
    logic [N-1:0][3:0] tmo_reg, tmo_next;

    // Frame capture
    frame_capture u_cap (
        .clk(clk),
        .sys_rst(sys_rst),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_last(rx_last),
        .done(cap_done),
        .bad(cap_bad),
        .ftype(cap_type),
        .func(cap_func),
        .phy_id(cap_phy),
        .op(cap_op),
        .min_code(cap_min),
        .max_code(cap_max),
        .upd(cap_upd),
        .tmo(cap_tmo),
        .crc(req_crc)
    );

    // Request decode
    assign sel = cap_phy[phy_ctl_pkg::PHY_IDX_W-1:0];
    assign onehot = N'(1) << sel;
    assign eff_min = (cap_min == phy_ctl_pkg::RATE_KEEP) ? min_reg[sel]
                                                         : cap_min;
    assign eff_max = (cap_max == phy_ctl_pkg::RATE_KEEP) ? max_reg[sel]
                                                         : cap_max;
    assign rate_bad = !phy_ctl_pkg::rate_code_ok(cap_min) ||
                      !phy_ctl_pkg::rate_code_ok(cap_max) ||
                      (eff_min > eff_max);
    assign op_known = (cap_op <= phy_ctl_pkg::OP_DISABLE) ||
                      (cap_op == phy_ctl_pkg::OP_CLEAR_LOG);
    assign self_conn = (cap_phy == conn_phy_id) &&
                       (cap_op >= phy_ctl_pkg::OP_LINK_RESET) &&
                       (cap_op <= phy_ctl_pkg::OP_DISABLE);

    // Execute a captured request
    always_comb begin
        resp_valid_next = 1'b0;
        drop_next = cap_bad;
        func_next = func_reg;
        result_next = result_reg;
        en_next = en_reg;
        lr_next = '0;
        hr_next = '0;
        ir_next = '0;
        sb_next = '0;
        ac_next = '0;
        ec_next = '0;
        min_next = min_reg;
        max_next = max_reg;
        tmo_next = tmo_reg;
        if (cap_done) begin
            if (cap_type != phy_ctl_pkg::FRAME_TYPE_REQ) begin
                drop_next = 1'b1;
            end else begin
                resp_valid_next = 1'b1;
                func_next = cap_func;
                if (!support_en || cap_func != phy_ctl_pkg::FUNC_PHY_CTL) begin
                    result_next = phy_ctl_pkg::RES_UNKNOWN_FUNC;
                end else if (cap_phy >= phy_ctl_pkg::NUM_PHYS_B) begin
                    result_next = phy_ctl_pkg::RES_PHY_VACANT;
                end else if (!op_known || rate_bad || self_conn) begin
                    result_next = phy_ctl_pkg::RES_FAILED;
                end else begin
                    result_next = phy_ctl_pkg::RES_ACCEPTED;
                    min_next[sel] = eff_min;
                    max_next[sel] = eff_max;
                    if (cap_upd) tmo_next[sel] = cap_tmo;
                    case (cap_op)
                        phy_ctl_pkg::OP_LINK_RESET: begin
                            en_next = en_reg | onehot;
                            sb_next = onehot;
                            if (phy_virtual[sel]) ir_next = onehot;
                            else lr_next = onehot;
                        end
                        phy_ctl_pkg::OP_HARD_RESET: begin
                            en_next = en_reg | onehot;
                            ac_next = onehot;
                            if (phy_virtual[sel]) begin
                                ir_next = onehot;
                            end else if (attached_sata[sel]) begin
                                lr_next = onehot;
                                sb_next = onehot;
                            end else begin
                                hr_next = onehot;
                            end
                        end
                        phy_ctl_pkg::OP_DISABLE: en_next = en_reg & ~onehot;
                        phy_ctl_pkg::OP_CLEAR_LOG: ec_next = onehot;
                        default: ;
                    endcase
                end
            end
        end
    end

    // State and output registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_valid_reg <= 1'b0;
            drop_reg <= 1'b0;
            func_reg <= 8'h00;
            result_reg <= 8'h00;
            en_reg <= '1;
            lr_reg <= '0;
            hr_reg <= '0;
            ir_reg <= '0;
            sb_reg <= '0;
            ac_reg <= '0;
            ec_reg <= '0;
            min_reg <= {N{phy_ctl_pkg::MIN_RATE_RST}};
            max_reg <= {N{phy_ctl_pkg::MAX_RATE_RST}};
            tmo_reg <= {N{phy_ctl_pkg::TMO_RST}};
        end else begin
            resp_valid_reg <= resp_valid_next;
            drop_reg <= drop_next;
            func_reg <= func_next;
            result_reg <= result_next;
            en_reg <= en_next;
            lr_reg <= lr_next;
            hr_reg <= hr_next;
            ir_reg <= ir_next;
            sb_reg <= sb_next;
            ac_reg <= ac_next;
            ec_reg <= ec_next;
            min_reg <= min_next;
            max_reg <= max_next;
            tmo_reg <= tmo_next;
        end
    end

    // Output drive
    assign resp_valid = resp_valid_reg;
    assign resp_function = func_reg;
    assign resp_result = result_reg;
    assign frame_drop = drop_reg;
    assign phy_enable = en_reg;
    assign link_reset = lr_reg;
    assign hard_reset = hr_reg;
    assign internal_reset = ir_reg;
    assign spinup_bypass = sb_reg;
    assign affil_clear = ac_reg;
    assign errlog_clear = ec_reg;
    assign min_rate = min_reg;
    assign max_rate = max_reg;
    assign pp_timeout = tmo_reg;

    // Checks on decode and action
    logic acc;
    assign acc = resp_valid_reg && result_reg == phy_ctl_pkg::RES_ACCEPTED;
    frame_type_a: assert property (@(posedge clk) disable iff (sys_rst)
        cap_done && cap_type != phy_ctl_pkg::FRAME_TYPE_REQ
        |=> !resp_valid_reg && drop_reg)
        else $error("wrong frame type answered");
    func_dispatch_a: assert property (@(posedge clk)
        disable iff (sys_rst)
        cap_done && cap_type == phy_ctl_pkg::FRAME_TYPE_REQ && support_en &&
        cap_func != phy_ctl_pkg::FUNC_PHY_CTL
        |=> resp_valid_reg && result_reg == phy_ctl_pkg::RES_UNKNOWN_FUNC)
        else $error("foreign function not rejected");
    no_support_a: assert property (@(posedge clk) disable iff (sys_rst)
        cap_done && !support_en |=> !acc && lr_reg == '0 && en_reg ==
        $past(en_reg))
        else $error("unsupported target acted");
    link_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_LINK_RESET
        |-> en_reg[sel] && sb_reg[sel] && !ac_reg[sel] &&
            (lr_reg[sel] != ir_reg[sel]))
        else $error("link reset action wrong");
    hard_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_HARD_RESET && !phy_virtual[sel] &&
        !attached_sata[sel] |-> hr_reg == onehot && ac_reg == onehot &&
        en_reg[sel])
        else $error("hard reset action wrong");
    sata_bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_HARD_RESET && !phy_virtual[sel] &&
        attached_sata[sel] |-> sb_reg[sel] && lr_reg[sel] && !hr_reg[sel])
        else $error("sata bypass missing");
    disable_phy_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_DISABLE |-> !en_reg[sel] &&
        en_reg == ($past(en_reg) & ~onehot))
        else $error("disable wrong");
    clear_log_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_CLEAR_LOG |-> ec_reg == onehot
        ##1 ec_reg == '0)
        else $error("error log clear wrong");
    self_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        cap_done && cap_type == phy_ctl_pkg::FRAME_TYPE_REQ && self_conn
        |=> !acc && lr_reg == '0 && hr_reg == '0 && en_reg == $past(en_reg))
        else $error("own phy not protected");
    rate_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        resp_valid_reg && !acc |-> $stable(min_reg) && $stable(max_reg))
        else $error("rates changed on failure");
    rate_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_min != phy_ctl_pkg::RATE_KEEP |-> min_reg[sel] == cap_min)
        else $error("new rate not applied");
    tmo_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        resp_valid_reg && !(acc && cap_upd) |-> $stable(tmo_reg))
        else $error("timeout loaded without update");
    bad_op_a: assert property (@(posedge clk) disable iff (sys_rst)
        resp_valid_reg && cap_func == phy_ctl_pkg::FUNC_PHY_CTL &&
        support_en && cap_phy < phy_ctl_pkg::NUM_PHYS_B && !op_known
        |-> result_reg == phy_ctl_pkg::RES_FAILED && sb_reg == '0 &&
        ec_reg == '0)
        else $error("invalid op not failed");
    nop_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc && cap_op == phy_ctl_pkg::OP_NOP |-> $stable(en_reg) &&
        lr_reg == '0 && ec_reg == '0)
        else $error("nop touched phy");
endmodule

// File: test/smp_initiator.sv
// Model of the remote initiator that streams request frames.
// Assumes the bench hands it 44-byte frames, sent whole or cut short.
// ============================================================
// Initiator model
module smp_initiator (
    // Clock
    input wire logic clk,
    // Request byte stream
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_last
);
    timeunit 1ns;
    timeprecision 1ps;

    // Valid and last idle low with no frame pending
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'hA5;
        rx_last = 1'b0;
    end

    // Released line shows a changing pattern, never the last byte
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            rx_valid = 1'b0;
            rx_last = 1'b0;
            rx_byte = ~rx_byte;
        end
    endtask

    task automatic send(input logic [7:0] f [44], input int gap,
                        input int len);
        idle(gap);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_byte = f[i];
            rx_last = (i == len - 1);
        end
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the phy control executor.
// Assumes the initiator model feeds the byte stream input.
// ============================================================
// Bench top
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = phy_ctl_pkg::NUM_PHYS;
    localparam logic [7:0] CONN = 8'h02;
    typedef struct packed {
        logic drop;
        logic [7:0] fn;
        logic [7:0] res;
        logic [5:0][N-1:0] pl;
        logic [N-1:0] en;
        logic [N-1:0][3:0] mn;
        logic [N-1:0][3:0] mx;
        logic [N-1:0][3:0] tm;
        logic [31:0] crc;
    } note_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic support_en = 1'b1;
    logic [7:0] conn_phy_id = CONN;
    logic [N-1:0] phy_virtual = 8'h10;
    logic [N-1:0] attached_sata = 8'h20;
    logic rx_valid, rx_last, resp_valid, frame_drop;
    logic [7:0] rx_byte, resp_function, resp_result;
    logic [31:0] req_crc;
    logic [N-1:0] phy_enable, link_reset, hard_reset, internal_reset;
    logic [N-1:0] spinup_bypass, affil_clear, errlog_clear;
    logic [N-1:0][3:0] min_rate, max_rate, pp_timeout;
    logic [N-1:0] en_m = '1;
    logic [N-1:0][3:0] min_m = {N{4'h8}};
    logic [N-1:0][3:0] max_m = {N{4'h9}};
    logic [N-1:0][3:0] tmo_m = '0;
    logic [3:0] codes [5] = '{4'h0, 4'h8, 4'h9, 4'h1, 4'hF};
    note_t q[$];
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'h404FC11B;

    // Clock
    always #5 clk = ~clk;

    smp_initiator smp_initiator_inst (.clk(clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last));
    phy_ctl_exec phy_ctl_exec_inst (.clk(clk), .sys_rst(sys_rst),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
        .support_en(support_en), .conn_phy_id(conn_phy_id),
        .phy_virtual(phy_virtual), .attached_sata(attached_sata),
        .resp_valid(resp_valid), .resp_function(resp_function),
        .resp_result(resp_result), .frame_drop(frame_drop),
        .req_crc(req_crc), .phy_enable(phy_enable), .link_reset(link_reset),
        .hard_reset(hard_reset), .internal_reset(internal_reset),
        .spinup_bypass(spinup_bypass), .affil_clear(affil_clear),
        .errlog_clear(errlog_clear), .min_rate(min_rate),
        .max_rate(max_rate), .pp_timeout(pp_timeout));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Build a frame, note the expected outcome, send it
    task automatic req(input logic [7:0] ft, fn, ph, op,
                       input logic [3:0] mn, mx, tm, input logic up,
                       input int gap);
        logic [7:0] f [44];
        note_t n;
        logic [3:0] a, b;
        int p;
        for (int i = 0; i < 44; i++) f[i] = 8'($random(seed));
        f[0] = ft;
        f[1] = fn;
        f[9] = ph;
        f[10] = op;
        f[32][7:4] = mn;
        f[33][7:4] = mx;
        f[34][7] = up;
        f[36][3:0] = tm;
        p = int'(ph[2:0]);
        a = (mn == 4'h0) ? min_m[p] : mn;
        b = (mx == 4'h0) ? max_m[p] : mx;
        n = '0;
        n.fn = fn;
        n.crc = {f[40], f[41], f[42], f[43]};
        if (ft != 8'h40) n.drop = 1'b1;
        else if (!support_en || fn != 8'h91) n.res = 8'h01;
        else if (ph >= 8'h08) n.res = 8'h10;
        else if (op == 8'h04 || op > 8'h05 || !(mn inside {0, 8, 9})
                 || !(mx inside {0, 8, 9}) || a > b
                 || (op inside {1, 2, 3} && ph == CONN)) n.res = 8'h02;
        else begin
            min_m[p] = a;
            max_m[p] = b;
            if (up) tmo_m[p] = tm;
            case (op)
                8'h01: begin
                    en_m[p] = 1'b1;
                    n.pl[2][p] = 1'b1;
                    if (phy_virtual[p]) n.pl[3][p] = 1'b1;
                    else n.pl[5][p] = 1'b1;
                end
                8'h02: begin
                    en_m[p] = 1'b1;
                    n.pl[1][p] = 1'b1;
                    if (phy_virtual[p]) n.pl[3][p] = 1'b1;
                    else if (attached_sata[p]) n.pl[5:4] = {8'(1 << p), 8'h00};
                    else n.pl[4][p] = 1'b1;
                    if (!phy_virtual[p] && attached_sata[p]) n.pl[2][p] = 1'b1;
                end
                8'h03: en_m[p] = 1'b0;
                8'h05: n.pl[0][p] = 1'b1;
                default: ;
            endcase
        end
        {n.en, n.mn, n.mx, n.tm} = {en_m, min_m, max_m, tmo_m};
        q.push_back(n);
        smp_initiator_inst.send(f, gap, 44);
    endtask

    // Cut frame: rx_last early, must be dropped with no action
    task automatic cut(input int len);
        logic [7:0] f [44];
        note_t n;
        for (int i = 0; i < 44; i++) f[i] = 8'($random(seed));
        f[0] = 8'h40;
        f[1] = 8'h91;
        n = '0;
        n.drop = 1'b1;
        {n.en, n.mn, n.mx, n.tm} = {en_m, min_m, max_m, tmo_m};
        q.push_back(n);
        smp_initiator_inst.send(f, 0, len);
    endtask

    // Release the line, wait for every note to be answered
    task automatic end_test(input string name);
        int k;
        smp_initiator_inst.idle(1);
        for (k = 0; k < 200 && q.size() != 0; k++) @(posedge clk);
        #1;
        if (q.size() != 0) begin
            fail_count++;
            $display("ERROR %0t responses missing", $time);
            tally_and_finish();
        end
        $display("test %s done", name);
    endtask

    // Compare each response with the oldest note
    always @(negedge clk) begin
        note_t n;
        if (!sys_rst && (resp_valid || frame_drop)) begin
            if (q.size() == 0) `CHK(1'b0, 1'b1) // unexpected answer
            else begin
                n = q.pop_front();
                `CHK({frame_drop, resp_valid}, {n.drop, !n.drop})
                if (resp_valid) `CHK({resp_function, resp_result, req_crc},
                    {n.fn, n.res, n.crc})
                `CHK({link_reset, hard_reset, internal_reset, spinup_bypass,
                    affil_clear, errlog_clear}, n.pl)
                `CHK({phy_enable, min_rate, max_rate, pp_timeout},
                    {n.en, n.mn, n.mx, n.tm})
            end
        end else if (!sys_rst)
            `CHK({link_reset, hard_reset, errlog_clear, affil_clear}, '0)
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (int o = 0; o < 8; o++) begin
            req(8'h40, 8'h91, 8'h01, 8'(o), 4'h0, 4'h0, 4'h0, 1'b0, 0);
        end
        end_test("all codes");
        req(8'h40, 8'h91, 8'h01, 8'h01, 4'h0, 4'h0, 4'h3, 1'b1, 0);
        req(8'h40, 8'h91, 8'h03, 8'h03, 4'h0, 4'h0, 4'h0, 1'b0, 0);
        req(8'h40, 8'h91, 8'h03, 8'h02, 4'h9, 4'h9, 4'h0, 1'b0, 0);
        for (int ph = 4; ph < 7; ph++) for (int o = 1; o < 3; o++)
            req(8'h40, 8'h91, 8'(ph), 8'(o), 4'h8, 4'h8, 4'h0, 1'b0, 1);
        for (int o = 1; o < 6; o++) begin
            req(8'h40, 8'h91, CONN, 8'(o), 4'h0, 4'h0, 4'h0, 1'b0, 0);
        end
        end_test("resets");
        for (int i = 0; i < 25; i++) req(8'h40, 8'h91, 8'h07, 8'h00,
            codes[i / 5], codes[i % 5], 4'(i), 1'(i), 0);
        req(8'h41, 8'h91, 8'h00, 8'h05, 4'h0, 4'h0, 4'h0, 1'b0, 0);
        req(8'h40, 8'h90, 8'h00, 8'h05, 4'h0, 4'h0, 4'h0, 1'b0, 2);
        req(8'h40, 8'h91, 8'h09, 8'h05, 4'h0, 4'h0, 4'h0, 1'b0, 0);
        cut(43);
        cut(10);
        end_test("rates and framing");
        support_en = 1'b0;
        req(8'h40, 8'h91, 8'h00, 8'h05, 4'h0, 4'h0, 4'h0, 1'b0, 0);
        end_test("unsupported");
        support_en = 1'b1;
        for (int i = 0; i < 40; i++) begin
            req(8'h40, 8'h91, 8'($unsigned($random(seed)) % 10),
                8'($unsigned($random(seed)) % 8),
                codes[$unsigned($random(seed)) % 5],
                codes[$unsigned($random(seed)) % 5], 4'($random(seed)),
                1'($random(seed)), $unsigned($random(seed)) % 3);
        end
        end_test("random");
        tally_and_finish();
    end
endmodule
